// ---- cpamd_consts.svh ----
// Purpose: constants for the addressing-mode decoder
// Assumes: included by the classifier, address and decoder design files
// Notes: opcode values below set this decoder's own encoding
`ifndef CPAMD_CONSTS_SVH
`define CPAMD_CONSTS_SVH

// Prefix bytes
`define CPAMD_PFX_Y 8'h90
`define CPAMD_PFX_IND_Y 8'h91
`define CPAMD_PFX_IND 8'h92

// Named opcodes, all inherent except the relative call 8'hAD
`define CPAMD_OP_IRQ_RET 8'h80
`define CPAMD_OP_RET 8'h81
`define CPAMD_OP_TRAP 8'h83
`define CPAMD_OP_HALT 8'h8E
`define CPAMD_OP_WAIT 8'h8F
`define CPAMD_OP_CARRY_CLR 8'h98
`define CPAMD_OP_CARRY_SET 8'h99
`define CPAMD_OP_MASK_CLR 8'h9A
`define CPAMD_OP_MASK_SET 8'h9B
`define CPAMD_OP_SP_RESET 8'h9C
`define CPAMD_OP_NOP 8'h9D
`define CPAMD_OP_BYTE_MULTIPLY 8'h42
`define CPAMD_OP_REL_CALL 8'hAD

// Interrupt mask levels
`define CPAMD_MASK_LVL3 2'h3
`define CPAMD_MASK_LVL0 2'h0
`define CPAMD_MASK_RST 2'h3

// Page zero upper byte and short indexed ceiling
`define CPAMD_PAGE0 8'h00
`define CPAMD_IDX_S_MAX 16'h01FE

`endif

// ---- cpamd_pkg.sv ----
// Purpose: types for the addressing-mode decoder
// Assumes: cpamd_consts.svh holds the numbers
// Notes: one packed struct carries all decoder state but the acks_reg beat counter
package cpamd_pkg;

    // The seventeen addressing modes
    typedef enum logic [4:0] {
        M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
        M_IND_S, M_IND_L, M_IIX_S, M_IIX_L, M_REL_D, M_REL_I,
        M_BIT_D, M_BIT_I, M_BTR_D, M_BTR_I
    } cpamd_mode_type;

    // Prefix seen ahead of the opcode
    typedef enum logic [1:0] {PFX_NONE, PFX_Y, PFX_IND, PFX_IND_Y} cpamd_pfx_type;

    // Thirteen instruction groups
    typedef enum logic [3:0] {
        G_LOAD, G_STACK, G_INCDEC, G_CMP, G_LOGIC, G_BIT, G_BTJ,
        G_ARITH, G_SHIFT, G_JUMP, G_COND, G_IRQ, G_FLAG
    } cpamd_grp_type;

    // Fetch sequencer, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_OP = 5'b00010,
        ST_ARG = 5'b00100,
        ST_PTR = 5'b01000,
        ST_CALC = 5'b10000
    } cpamd_fsm_type;

    typedef struct packed {
        cpamd_fsm_type fsm;
        logic [15:0] pc;
        cpamd_pfx_type pfx;
        logic [7:0] opcode;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] phi;
        logic [7:0] plo;
        logic argi;
        logic ptri;
        logic done;
        logic [15:0] ea;
        logic [15:0] tgt;
        logic [7:0] imm;
        logic [2:0] len;
        cpamd_mode_type mode;
        cpamd_grp_type grp;
        logic ill;
        logic use_y;
        logic short_only;
        logic trap;
        logic wait_irq;
        logic halt;
        logic [1:0] mask;
    } cpamd_state_type;

endpackage

// ---- cpamd_classify.sv ----
// Purpose: opcode and prefix to mode, length, group
// Assumes: opcode and prefix are stable in the same cycle
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cpamd_consts.svh"
module cpamd_classify (
    input wire logic [7:0] opcode,
    input wire cpamd_pkg::cpamd_pfx_type pfx,
    output cpamd_pkg::cpamd_mode_type mode,
    output logic use_y,
    output logic [1:0] arg_cnt,
    output logic [1:0] ptr_cnt,
    output cpamd_pkg::cpamd_grp_type grp,
    output logic short_only,
    output logic illegal
);
    import cpamd_pkg::*;
    logic [3:0] hi;
    logic [3:0] lo;
    logic ind;
    logic jmp;

    // Mode from the high nibble, widened by the indirect prefix
    always_comb begin
        hi = opcode[7:4];
        lo = opcode[3:0];
        ind = (pfx == PFX_IND) || (pfx == PFX_IND_Y);
        jmp = (hi >= 4'hA) && (lo == 4'hC || lo == 4'hD);
        use_y = (pfx == PFX_Y) || (pfx == PFX_IND_Y);
        case (hi)
            4'h0: mode = ind ? M_BTR_I : M_BTR_D;
            4'h1: mode = ind ? M_BIT_I : M_BIT_D;
            4'h2: mode = ind ? M_REL_I : M_REL_D;
            4'h3, 4'hB: mode = ind ? M_IND_S : M_DIR_S;
            4'h6, 4'hE: mode = ind ? M_IIX_S : M_IDX_S;
            4'h7, 4'hF: mode = M_IDX_0;
            4'hA: mode = (opcode == `CPAMD_OP_REL_CALL) ? (ind ? M_REL_I : M_REL_D) : M_IMM;
            4'hC: mode = ind ? M_IND_L : M_DIR_L;
            4'hD: mode = ind ? M_IIX_L : M_IDX_L;
            default: mode = M_INH;
        endcase
        // Bytes after the opcode and pointer bytes read from memory
        case (mode)
            M_INH, M_IDX_0: arg_cnt = 2'd0;
            M_DIR_L, M_IDX_L, M_BTR_D, M_BTR_I: arg_cnt = 2'd2;
            default: arg_cnt = 2'd1;
        endcase
        case (mode)
            M_IND_L, M_IIX_L: ptr_cnt = 2'd2;
            M_IND_S, M_IIX_S, M_REL_I, M_BIT_I, M_BTR_I: ptr_cnt = 2'd1;
            default: ptr_cnt = 2'd0;
        endcase
        // Memory-to-memory and call/jump classes stay short
        short_only = (hi <= 4'h3) || hi == 4'h6 || hi == 4'h7 || jmp;
        illegal = (jmp && (hi == 4'hC || hi == 4'hD))
            || (mode == M_IMM && (lo == 4'h7 || lo == 4'hF || lo == 4'hC))
            || (pfx == PFX_Y && hi <= 4'h2)
            || (pfx == PFX_IND_Y && !(hi == 4'h6 || hi == 4'hD || hi == 4'hE))
            || (pfx == PFX_IND && (mode == M_INH || mode == M_IMM || mode == M_IDX_0));
        // Group from the opcode map
        if (hi == 4'h0) begin
            grp = G_BTJ;
        end else if (hi == 4'h1) begin
            grp = G_BIT;
        end else if (hi == 4'h2) begin
            grp = (lo <= 4'h1) ? G_JUMP : G_COND;
        end else if (opcode == `CPAMD_OP_BYTE_MULTIPLY) begin
            grp = G_ARITH;
        end else if (hi <= 4'h7) begin
            case (lo)
                4'h0, 4'h3: grp = G_LOGIC;
                4'hA, 4'hC: grp = G_INCDEC;
                4'hD: grp = G_CMP;
                4'hF: grp = G_LOAD;
                default: grp = G_SHIFT;
            endcase
        end else if (hi <= 4'h9) begin
            case (opcode)
                `CPAMD_OP_IRQ_RET, `CPAMD_OP_TRAP, `CPAMD_OP_HALT, `CPAMD_OP_WAIT: grp = G_IRQ;
                `CPAMD_OP_RET, `CPAMD_OP_NOP: grp = G_JUMP;
                `CPAMD_OP_CARRY_CLR, `CPAMD_OP_CARRY_SET: grp = G_FLAG;
                `CPAMD_OP_MASK_CLR, `CPAMD_OP_MASK_SET: grp = G_FLAG;
                8'h84, 8'h85, 8'h86, 8'h88, 8'h89, `CPAMD_OP_SP_RESET: grp = G_STACK;
                default: grp = G_LOAD;
            endcase
        end else begin
            case (lo)
                4'h0, 4'h2, 4'h9, 4'hB: grp = G_ARITH;
                4'h1, 4'h3, 4'h5: grp = G_CMP;
                4'h4, 4'h8, 4'hA: grp = G_LOGIC;
                4'hC, 4'hD: grp = G_JUMP;
                default: grp = G_LOAD;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- cpamd_ea_calc.sv ----
// Purpose: effective address and relative target
// Assumes: fetched bytes held in registers
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cpamd_consts.svh"
module cpamd_ea_calc (
    input wire cpamd_pkg::cpamd_mode_type mode,
    input wire logic [7:0] idx,
    input wire logic [7:0] b1,
    input wire logic [7:0] b2,
    input wire logic [7:0] phi,
    input wire logic [7:0] plo,
    input wire logic [15:0] pc_next,
    output logic [15:0] ea,
    output logic [15:0] tgt
);
    import cpamd_pkg::*;
    logic [7:0] off;
    logic [15:0] idx_w;

    // Unsigned index sums, zero-extended so short forms reach 1FE
    always_comb begin
        idx_w = {`CPAMD_PAGE0, idx};
        case (mode)
            M_DIR_S, M_BIT_D, M_BTR_D: ea = {`CPAMD_PAGE0, b1};
            M_DIR_L: ea = {b1, b2};
            M_IDX_0: ea = idx_w;
            M_IDX_S: ea = {`CPAMD_PAGE0, b1} + idx_w;
            M_IDX_L: ea = {b1, b2} + idx_w;
            M_IND_S, M_BIT_I, M_BTR_I: ea = {`CPAMD_PAGE0, plo};
            M_IND_L: ea = {phi, plo};
            M_IIX_S: ea = {`CPAMD_PAGE0, plo} + idx_w;
            M_IIX_L: ea = {phi, plo} + idx_w;
            default: ea = 16'h0000;
        endcase
        // Offset byte: after opcode, from memory, or after a bit address
        case (mode)
            M_REL_I: off = plo;
            M_BTR_D, M_BTR_I: off = b2;
            default: off = b1;
        endcase
        tgt = pc_next + {{8{off[7]}}, off};
    end
endmodule
`default_nettype wire

// ---- cpamd_decoder.sv ----
// Purpose: fetch sequencer and addressing-mode decoder of the core
// Assumes: memory answers rd_req with rd_ack, on the same clock or after wait states
// Notes: one instruction per start; next_pc holds until next start, trap/wait/halt events pulse in the done cycle, other results hold until next done
`timescale 1ns/1ps
`default_nettype none
`include "cpamd_consts.svh"

//////////////////////////////////////////////////////////////////////
module cpamd_decoder (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] x_in,
    input wire logic [7:0] y_in,
    output logic rd_req,
    output logic [15:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_ack,
    output logic busy,
    output logic done,
    output logic [15:0] ea,
    output logic [15:0] jump_target,
    output logic [15:0] next_pc,
    output logic [7:0] imm_data,
    output logic [2:0] instr_len,
    output cpamd_pkg::cpamd_mode_type mode,
    output cpamd_pkg::cpamd_grp_type group,
    output logic illegal,
    output logic use_y,
    output logic short_only,
    output logic trap_evt,
    output logic wait_evt,
    output logic halt_evt,
    output logic [1:0] mask_level
);
    import cpamd_pkg::*;

    cpamd_state_type s_reg;
    cpamd_state_type s_next;
    logic [7:0] op_cur;
    logic [7:0] idx;
    logic is_pfx;
    cpamd_mode_type c_mode;
    cpamd_grp_type c_grp;
    logic c_use_y;
    logic [1:0] c_arg;
    logic [1:0] c_ptr;
    logic c_short;
    logic c_ill;
    logic [15:0] c_ea;
    logic [15:0] c_tgt;
    logic [3:0] acks_reg;

    //////////////////////////////////////////////////////////////////
    // Decode of the byte on the bus in the opcode cycle, else held
    assign op_cur = (s_reg.fsm == ST_OP) ? rd_data : s_reg.opcode;
    assign idx = c_use_y ? y_in : x_in;
    assign is_pfx = (rd_data == `CPAMD_PFX_Y) || (rd_data == `CPAMD_PFX_IND)
        || (rd_data == `CPAMD_PFX_IND_Y);

    cpamd_classify u_cls (
        .opcode(op_cur),
        .pfx(s_reg.pfx),
        .mode(c_mode),
        .use_y(c_use_y),
        .arg_cnt(c_arg),
        .ptr_cnt(c_ptr),
        .grp(c_grp),
        .short_only(c_short),
        .illegal(c_ill)
    );

    cpamd_ea_calc u_calc (
        .mode(c_mode),
        .idx(idx),
        .b1(s_reg.b1),
        .b2(s_reg.b2),
        .phi(s_reg.phi),
        .plo(s_reg.plo),
        .pc_next(s_reg.pc),
        .ea(c_ea),
        .tgt(c_tgt)
    );

    //////////////////////////////////////////////////////////////////
    // Next state: prefix, opcode, operand bytes, pointer, result
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.trap = 1'b0;
        s_next.wait_irq = 1'b0;
        s_next.halt = 1'b0;
        rd_req = 1'b0;
        rd_addr = s_reg.pc;
        unique case (s_reg.fsm)
            ST_IDLE: begin
                if (start) begin
                    s_next.pc = pc_in;
                    s_next.pfx = PFX_NONE;
                    s_next.fsm = ST_OP;
                end
            end
            ST_OP: begin
                rd_req = 1'b1;
                if (rd_ack) begin
                    s_next.pc = s_reg.pc + 16'h0001;
                    // Only one prefix counts; a second is taken as opcode
                    if (s_reg.pfx == PFX_NONE && is_pfx) begin
                        if (rd_data == `CPAMD_PFX_Y) begin
                            s_next.pfx = PFX_Y;
                        end else if (rd_data == `CPAMD_PFX_IND) begin
                            s_next.pfx = PFX_IND;
                        end else begin
                            s_next.pfx = PFX_IND_Y;
                        end
                    end else begin
                        s_next.opcode = rd_data;
                        s_next.argi = 1'b0;
                        s_next.ptri = 1'b0;
                        s_next.phi = 8'h00;
                        if (c_arg != 2'd0) begin
                            s_next.fsm = ST_ARG;
                        end else if (c_ptr != 2'd0) begin
                            s_next.fsm = ST_PTR;
                        end else begin
                            s_next.fsm = ST_CALC;
                        end
                    end
                end
            end
            ST_ARG: begin
                rd_req = 1'b1;
                if (rd_ack) begin
                    s_next.pc = s_reg.pc + 16'h0001;
                    s_next.argi = 1'b1;
                    if (!s_reg.argi) begin
                        s_next.b1 = rd_data;
                    end else begin
                        s_next.b2 = rd_data;
                    end
                    if (s_reg.argi || c_arg == 2'd1) begin
                        s_next.fsm = (c_ptr != 2'd0) ? ST_PTR : ST_CALC;
                    end
                end
            end
            ST_PTR: begin
                // Pointer lives in page zero; a word pointer may cross to 0100
                rd_req = 1'b1;
                rd_addr = {`CPAMD_PAGE0, s_reg.b1} + {15'h0000, s_reg.ptri};
                if (rd_ack) begin
                    s_next.ptri = 1'b1;
                    if (c_ptr == 2'd2 && !s_reg.ptri) begin
                        s_next.phi = rd_data;
                    end else begin
                        s_next.plo = rd_data;
                    end
                    if (s_reg.ptri || c_ptr == 2'd1) begin
                        s_next.fsm = ST_CALC;
                    end
                end
            end
            ST_CALC: begin
                s_next.ea = c_ea;
                s_next.tgt = c_tgt;
                s_next.imm = s_reg.b1;
                s_next.len = {1'b0, c_arg} + 3'd1 + {2'b00, s_reg.pfx != PFX_NONE};
                s_next.mode = c_mode;
                s_next.grp = c_grp;
                s_next.ill = c_ill;
                s_next.use_y = c_use_y;
                s_next.short_only = c_short;
                s_next.done = 1'b1;
                // Core events fire only for the unprefixed one-byte forms
                if (s_reg.pfx == PFX_NONE) begin
                    s_next.trap = (s_reg.opcode == `CPAMD_OP_TRAP);
                    s_next.wait_irq = (s_reg.opcode == `CPAMD_OP_WAIT);
                    s_next.halt = (s_reg.opcode == `CPAMD_OP_HALT);
                    if (s_reg.opcode == `CPAMD_OP_MASK_SET) begin
                        s_next.mask = `CPAMD_MASK_LVL3;
                    end else if (s_reg.opcode == `CPAMD_OP_MASK_CLR) begin
                        s_next.mask = `CPAMD_MASK_LVL0;
                    end
                end
                s_next.fsm = ST_IDLE;
            end
            default: begin
                s_next.fsm = ST_IDLE;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '{fsm: ST_IDLE, pfx: PFX_NONE, mode: M_INH, grp: G_LOAD,
                mask: `CPAMD_MASK_RST, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign busy = (s_reg.fsm != ST_IDLE);
    assign done = s_reg.done;
    assign ea = s_reg.ea;
    assign jump_target = s_reg.tgt;
    assign next_pc = s_reg.pc;
    assign imm_data = s_reg.imm;
    assign instr_len = s_reg.len;
    assign mode = s_reg.mode;
    assign group = s_reg.grp;
    assign illegal = s_reg.ill;
    assign use_y = s_reg.use_y;
    assign short_only = s_reg.short_only;
    assign trap_evt = s_reg.trap;
    assign wait_evt = s_reg.wait_irq;
    assign halt_evt = s_reg.halt;
    assign mask_level = s_reg.mask;

    //////////////////////////////////////////////////////////////////
    // Bus beats since the last accepted start, checked at done
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acks_reg <= 4'h0;
        end else if (s_reg.fsm == ST_IDLE && start) begin
            acks_reg <= 4'h0;
        end else if (rd_req && rd_ack) begin
            acks_reg <= acks_reg + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence seq_calc_op(logic [7:0] op);
        s_reg.fsm == ST_CALC && s_reg.pfx == PFX_NONE && s_reg.opcode == op;
    endsequence

    sequence seq_result(cpamd_mode_type m);
        done && mode == m;
    endsequence

    AST_INH_ONE_BYTE: assert property (
        seq_result(M_INH) |-> instr_len == 3'd1 + {2'b00, s_reg.pfx != PFX_NONE})
        else $error("inherent length not one byte");
    AST_IMM_CLASS: assert property (
        seq_result(M_IMM) ##0 !illegal |-> instr_len >= 3'd2
        && (group inside {G_LOAD, G_CMP, G_LOGIC, G_ARITH}))
        else $error("immediate length or class wrong");
    AST_DIR_S_PAGE0: assert property (
        seq_result(M_DIR_S) |-> ea == {8'h00, s_reg.b1})
        else $error("short direct address wrong");
    AST_DIR_L_WORD: assert property (
        seq_result(M_DIR_L) |-> ea == {s_reg.b1, s_reg.b2} && acks_reg >= 4'd3)
        else $error("long direct address wrong");
    AST_IDX_S_SUM: assert property (
        seq_result(M_IDX_S) |-> ea <= `CPAMD_IDX_S_MAX && ea[15:9] == 7'h00)
        else $error("short indexed out of range");
    AST_IDX0_PAGE0: assert property (
        seq_result(M_IDX_0) |-> ea[15:8] == 8'h00 && instr_len <= 3'd2)
        else $error("no-offset indexed wrong");
    AST_PTR_PAGE0: assert property (
        rd_req && s_reg.fsm == ST_PTR |-> rd_addr[15:9] == 7'h00)
        else $error("pointer read outside page zero");
    AST_BEAT_COUNT: assert property (
        done |-> acks_reg == {1'b0, instr_len} + {2'b00, c_ptr})
        else $error("bus beats do not match length and pointer");
    AST_REL_TARGET: assert property (
        seq_result(M_REL_D) |-> jump_target == next_pc + {{8{s_reg.b1[7]}}, s_reg.b1})
        else $error("relative target wrong");
    AST_MASK_SET: assert property (
        seq_calc_op(`CPAMD_OP_MASK_SET) |=> done && mask_level == 2'h3)
        else $error("mask set did not reach level 3");
    AST_MASK_CLR: assert property (
        seq_calc_op(`CPAMD_OP_MASK_CLR) |=> done && mask_level == 2'h0)
        else $error("mask clear did not reach level 0");
    AST_HALT_EVT: assert property (
        seq_calc_op(`CPAMD_OP_HALT) |=> halt_evt && instr_len == 3'd1 ##1 !halt_evt)
        else $error("halt event missing or long");
    AST_PFX_Y: assert property (
        done && s_reg.pfx == PFX_Y && !illegal |-> use_y)
        else $error("second index not selected");
    AST_SHORT_ONLY: assert property (
        done && short_only && !illegal |-> !(mode inside {M_DIR_L, M_IDX_L}))
        else $error("long form on short-only class");
endmodule
`default_nettype wire

// ---- cpamd_mem_model.sv ----
// Purpose: program and data memory behind the decoder's read port
// Assumes: reads only; bench fills the array by hierarchical reference
// Notes: slow adds one wait state to every beat
`timescale 1ns/1ps
`default_nettype none
module cpamd_mem_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_ack
);
    logic [7:0] mem [0:65535];
    logic waited_reg;
    logic [7:0] last_reg;
    // Clear store so unset pointers read as zero
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end
    // Answer at once, or after one stalled cycle when slow
    assign rd_ack = rd_req && (!slow || waited_reg);
    // Off-answer the bus flips, so a late sample never looks valid
    assign rd_data = rd_ack ? mem[rd_addr] : ~last_reg;
    // Stall and last-byte tracking
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waited_reg <= 1'b0;
            last_reg <= 8'h00;
        end else begin
            waited_reg <= rd_req && !rd_ack;
            if (rd_ack) begin
                last_reg <= rd_data;
            end
        end
    end
endmodule
`default_nettype wire

// ---- cpamd_decoder_test.sv ----
// Purpose: self-checking bench of the addressing-mode decoder
// Assumes: inputs driven on falling edges
// Notes: results are judged in the done cycle
`timescale 1ns/1ps
`default_nettype none
module cpamd_decoder_test;
    import cpamd_pkg::*;
    logic clk, reset, start, slow, rd_req, rd_ack, busy, done, illegal, use_y, short_only;
    logic trap_evt, wait_evt, halt_evt;
    logic [15:0] pc_in, rd_addr, ea, jump_target, next_pc;
    logic [7:0] x_in, y_in, rd_data, imm_data;
    logic [2:0] instr_len;
    logic [1:0] mask_level;
    cpamd_mode_type mode;
    cpamd_grp_type group;
    int errors = 0;
    int checks = 0;
    cpamd_decoder DUT (.clk(clk), .reset(reset), .start(start), .pc_in(pc_in), .x_in(x_in),
        .y_in(y_in), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack),
        .busy(busy), .done(done), .ea(ea), .jump_target(jump_target), .next_pc(next_pc),
        .imm_data(imm_data), .instr_len(instr_len), .mode(mode), .group(group),
        .illegal(illegal), .use_y(use_y), .short_only(short_only), .trap_evt(trap_evt),
        .wait_evt(wait_evt), .halt_evt(halt_evt), .mask_level(mask_level));
    cpamd_mem_model mem_model (.clk(clk), .reset(reset), .slow(slow), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Load bytes at pc, start once, wait boundedly for done
    task automatic exec(input logic [15:0] pc, input logic [31:0] code, input int n,
        input logic [7:0] x, input logic [7:0] y);
        int k;
        for (k = 0; k < n; k++) mem_model.mem[16'(pc + k)] = code[31 - 8 * k -: 8];
        @(negedge clk);
        pc_in = pc;
        x_in = x;
        y_in = y;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
        end
        if (k == 60) begin
            errors++;
            $display("Error at %0t: no done", $time);
            give_verdict();
        end
    endtask
    // Common address check: ea, length, next pc, mode, index choice, legality
    task automatic acase(input logic [15:0] pc, input logic [31:0] code, input int n,
        input logic [7:0] x, input logic [7:0] y, input logic [15:0] e, input cpamd_mode_type m,
        input logic uy);
        exec(pc, code, n, x, y);
        cmp(ea, e);
        cmp(16'(instr_len), 16'(n));
        cmp(next_pc, 16'(pc + n));
        cmp(16'(mode), 16'(m));
        cmp(16'(use_y), 16'(uy));
        cmp(16'(illegal), 16'h0000);
    endtask
    // Reset in mid-instruction returns to idle with the mask at its reset level
    task automatic reset_midway();
        exec(16'h0500, 32'h9A000000, 1, 8'h00, 8'h00);
        @(negedge clk);
        pc_in = 16'h0A00;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        reset = 1'b1;
        @(negedge clk);
        cmp({13'h0, busy, done, rd_req}, 16'h0000);
        cmp(16'(mask_level), 16'h0003);
        reset = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic inherent_ops();
        logic [7:0] ops [3] = '{8'h83, 8'h8F, 8'h8E};
        exec(16'h0500, 32'h9A000000, 1, 8'h00, 8'h00);
        cmp(16'(mask_level), 16'h0000);
        exec(16'h0500, 32'h9B000000, 1, 8'h00, 8'h00);
        cmp(16'(mask_level), 16'h0003);
        cmp(16'(group), 16'(G_FLAG));
        for (int i = 0; i < 3; i++) begin
            exec(16'h0500, {ops[i], 24'h0}, 1, 8'h00, 8'h00);
            cmp({13'h0, trap_evt, wait_evt, halt_evt}, 16'(4 >> i));
            cmp(16'(instr_len), 16'h0001);
            cmp(16'(group), 16'(G_IRQ));
        end
    endtask
    task automatic direct_indexed();
        exec(16'h0600, 32'hA6550000, 2, 8'h00, 8'h00);
        cmp({8'h00, imm_data}, 16'h0055);
        cmp(16'(instr_len), 16'h0002);
        exec(16'h0600, 32'hA7550000, 2, 8'h00, 8'h00);
        cmp(16'(illegal), 16'h0001);
        acase(16'h0610, 32'hB6100000, 2, 8'h00, 8'h00, 16'h0010, M_DIR_S, 1'b0);
        acase(16'h0620, 32'hC6123400, 3, 8'h00, 8'h00, 16'h1234, M_DIR_L, 1'b0);
        acase(16'h0630, 32'hF6000000, 1, 8'hFF, 8'h00, 16'h00FF, M_IDX_0, 1'b0);
        acase(16'h0640, 32'hE6FF0000, 2, 8'hFF, 8'h00, 16'h01FE, M_IDX_S, 1'b0);
        acase(16'h0650, 32'h90E6FF00, 3, 8'h00, 8'h80, 16'h017F, M_IDX_S, 1'b1);
        acase(16'h0660, 32'hD6120000, 3, 8'h34, 8'h00, 16'h1234, M_IDX_L, 1'b0);
    endtask
    task automatic indirect_modes();
        mem_model.mem[16'h0010] = 8'h44;
        mem_model.mem[16'h0011] = 8'hCD;
        mem_model.mem[16'h0020] = 8'hF0;
        mem_model.mem[16'h0030] = 8'h12;
        acase(16'h0700, 32'h92B61000, 3, 8'h00, 8'h00, 16'h0044, M_IND_S, 1'b0);
        acase(16'h0710, 32'h92C61000, 3, 8'h00, 8'h00, 16'h44CD, M_IND_L, 1'b0);
        acase(16'h0720, 32'h92E62000, 3, 8'h10, 8'h00, 16'h0100, M_IIX_S, 1'b0);
        acase(16'h0730, 32'h91E62000, 3, 8'h00, 8'h0F, 16'h00FF, M_IIX_S, 1'b1);
        acase(16'h0740, 32'h92D63000, 3, 8'h34, 8'h00, 16'h1234, M_IIX_L, 1'b0);
    endtask
    task automatic relative_modes();
        mem_model.mem[16'h0040] = 8'h05;
        exec(16'h0200, 32'h20FE0000, 2, 8'h00, 8'h00);
        cmp(jump_target, 16'h0200);
        exec(16'h0300, 32'h92204000, 3, 8'h00, 8'h00);
        cmp(jump_target, 16'h0308);
        cmp(16'(mode), 16'(M_REL_I));
        exec(16'h0400, 32'hAD800000, 2, 8'h00, 8'h00);
        cmp(jump_target, 16'h0382);
        acase(16'h0900, 32'h00100500, 3, 8'h00, 8'h00, 16'h0010, M_BTR_D, 1'b0);
        cmp(jump_target, 16'h0908);
        acase(16'h0910, 32'h92004005, 4, 8'h00, 8'h00, 16'h0005, M_BTR_I, 1'b0);
        cmp(jump_target, 16'h0919);
        acase(16'h0920, 32'h10100000, 2, 8'h00, 8'h00, 16'h0010, M_BIT_D, 1'b0);
    endtask
    task automatic class_limits();
        exec(16'h0800, 32'h3C100000, 2, 8'h00, 8'h00);
        cmp(16'(short_only), 16'h0001);
        exec(16'h0810, 32'hCD123400, 3, 8'h00, 8'h00);
        cmp(16'(illegal), 16'h0001);
        slow = 1'b1;
        acase(16'h0820, 32'h92C61000, 3, 8'h00, 8'h00, 16'h44CD, M_IND_L, 1'b0);
        slow = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        start = 1'b0;
        slow = 1'b0;
        pc_in = 16'h0000;
        x_in = 8'h00;
        y_in = 8'h00;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        inherent_ops();
        reset_midway();
        direct_indexed();
        indirect_modes();
        relative_modes();
        class_limits();
        give_verdict();
    end
endmodule
`default_nettype wire
